// *** hdl/frsw_pkg.sv ***
package frsw_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] CFG_OFS    = 8'h04;
   localparam logic [7:0] LIMIT_OFS  = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   // ctrl bits, write one to act, self clearing
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STOP_BIT  = 1;
   localparam int CTRL_LSLP_BIT  = 2;
   localparam int CTRL_RWAKE_BIT = 3;
   localparam int CTRL_TRIG_BIT  = 4;
   // cfg fields
   localparam int CFG_KEY_LSB    = 0;
   localparam int CFG_KEY_W      = 11;
   localparam int CFG_OSF_BIT    = 16;
   localparam int CFG_ASLP_BIT   = 17;
   localparam int CFG_EXTSYN_BIT = 18;
   localparam int CFG_WCH_BIT    = 19;
   localparam int CFG_CHEN_LSB   = 20;
   localparam logic [31:0] CFG_RST = 32'h0030_0000;
   // limit fields, 8 bits each
   localparam int LIM_PAS_LSB = 0;
   localparam int LIM_FAT_LSB = 8;
   localparam int LIM_ACT_LSB = 16;
   localparam logic [31:0] LIMIT_RST = 32'h0002_0402;
   localparam int CNT_W = 8;
   // axi answers
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [2:0] {
      ST_DEFCFG, ST_CONFIG, ST_READY, ST_WAKEUP, ST_NACTIVE, ST_NPASSIVE, ST_HALT
   } frsw_state_t;
endpackage : frsw_pkg

// *** hdl/frsw_top.sv ***
// Function
// - communication starts only after two coldstart nodes contribute startup frames.
// - at most one distinct startup frame leaves this node.
// - key slot zero means no startup frame via key slot.
// - nonzero key slot sends null startup frame automatically once started.
// - output session startup frame flag makes node coldstart and transmit it.
// - start trigger moves Default Config to Config; without external sync, start raises it internally.
// - Config moves to Ready once startup begins; stays only on failure.
// - in Ready coldstart nodes initiate integration, others join.
// - Ready to Normal Active needs all channels awake and integration success.
// - all awake means pattern on every enabled channel, local wakeup, or not asleep; nothing sets lwake, so local wakeup never counts.
// - node resets awake; startup then as without wakeup.
// - local sleep setting puts node to sleep once.
// - auto sleep option sleeps now and again at every stop out of Halt.
// - started asleep, Ready holds integration until all channels awake.
// - remote wake in Ready enters Wakeup, sends pattern, back when the configured wake channel is woken.
// - remote wake accepted before start after sleep, or during Ready wait.
// - Normal Active to Passive when failed count reaches passive limit.
// - Passive to Active when valid term count reaches passive-to-active limit.
// - Halt on failed count reaching fatal limit or stop during operation.
// - stop in Halt returns to Default Config.
// - startup frame must differ from other coldstart nodes' frames.
`timescale 1ns/100ps
module frsw_top
   import frsw_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              ext_start_trigger,
   input  wire logic              startup_ok,
   input  wire logic              startup_fail,
   input  wire logic              integration_ok,
   input  wire logic [1:0]        wake_seen,
   input  wire logic              cc_failed,
   input  wire logic              cc_valid,
   output logic                   startup_frame_en,
   output logic [CFG_KEY_W-1:0]   startup_slot,
   output logic                   startup_null_payload,
   output logic                   coldstart_integrate,
   output logic                   join_integrate,
   output logic                   wake_pattern_en,
   output logic                   wake_channel,
   output logic                   comm_active,
   output logic [2:0]             poc_state
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              aw_got;
      logic [7:0]        aw_addr;
      logic              w_got;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic [31:0]       cfg;
      logic [31:0]       limit;
      frsw_state_t       st;
      logic              asleep;
      logic              rwake_pend;
      logic              lwake;
      logic [1:0]        woken;
      logic [CNT_W-1:0]  fail_cnt;
      logic [CNT_W-1:0]  valid_cnt;
      logic              sf_en;
      logic              cs_int;
      logic              join_int;
      logic              wpat;
      logic              comm;
   } frsw_reg_t;

   frsw_reg_t r_q, r_d;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return m;
   endfunction : merge

   logic [CFG_KEY_W-1:0] key_slot;
   logic                 osf_flag;
   logic                 auto_sleep;
   logic                 ext_sync;
   logic [1:0]           ch_en;
   logic [CNT_W-1:0]     lim_pas;
   logic [CNT_W-1:0]     lim_fat;
   logic [CNT_W-1:0]     lim_act;
   logic                 wr_fire;
   logic [31:0]          ctrl_wr;
   logic                 c_start;
   logic                 c_stop;
   logic                 c_lslp;
   logic                 c_rwake;
   logic                 trig;
   logic                 all_awake;
   logic                 coldstart;
   logic [CNT_W-1:0]     fail_nx;

   assign key_slot   = r_q.cfg[CFG_KEY_LSB +: CFG_KEY_W];
   assign osf_flag   = r_q.cfg[CFG_OSF_BIT];
   assign auto_sleep = r_q.cfg[CFG_ASLP_BIT];
   assign ext_sync   = r_q.cfg[CFG_EXTSYN_BIT];
   assign ch_en      = r_q.cfg[CFG_CHEN_LSB +: 2];
   assign lim_pas    = r_q.limit[LIM_PAS_LSB +: CNT_W];
   assign lim_fat    = r_q.limit[LIM_FAT_LSB +: CNT_W];
   assign lim_act    = r_q.limit[LIM_ACT_LSB +: CNT_W];
   assign wr_fire    = r_q.aw_got && r_q.w_got && !r_q.bvalid;
   // control pulses only when the low byte lane is written
   assign ctrl_wr    = (wr_fire && r_q.aw_addr == CTRL_OFS && r_q.w_strb[0]) ? r_q.w_data
                                                                              : 32'h0;
   assign c_start    = ctrl_wr[CTRL_START_BIT] && r_q.w_strb[0];
   assign c_stop     = ctrl_wr[CTRL_STOP_BIT] && r_q.w_strb[0];
   assign c_lslp     = ctrl_wr[CTRL_LSLP_BIT] && r_q.w_strb[0];
   assign c_rwake    = ctrl_wr[CTRL_RWAKE_BIT] && r_q.w_strb[0];
   // no external sync: start raises the trigger itself
   assign trig       = ext_sync ? (ext_start_trigger || ctrl_wr[CTRL_TRIG_BIT])
                                : c_start;
   // one key slot or one flagged output frame, key slot wins
   assign coldstart  = (key_slot != '0) || osf_flag;
   assign all_awake  = !r_q.asleep || r_q.lwake
                       || ((r_q.woken & ch_en) == ch_en);
   assign fail_nx    = (cc_failed && r_q.fail_cnt != '1) ? r_q.fail_cnt + 1'b1 : r_q.fail_cnt;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      r_d = r_q;
      // axi write path
      if (s_axi_awvalid && s_axi_awready) begin
         r_d.aw_got  = 1'b1;
         r_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         r_d.w_got  = 1'b1;
         r_d.w_data = s_axi_wdata;
         r_d.w_strb = s_axi_wstrb;
      end
      if (wr_fire) begin
         r_d.aw_got = 1'b0;
         r_d.w_got  = 1'b0;
         r_d.bvalid = 1'b1;
         r_d.bresp  = RESP_OKAY;
         case (r_q.aw_addr)
            CTRL_OFS: begin
            end
            CFG_OFS: begin
               r_d.cfg = merge(r_q.cfg, r_q.w_data, r_q.w_strb);
            end
            LIMIT_OFS: begin
               r_d.limit = merge(r_q.limit, r_q.w_data, r_q.w_strb);
            end
            STATUS_OFS: begin
            end
            default: begin
               r_d.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (r_q.bvalid && s_axi_bready) begin
         r_d.bvalid = 1'b0;
      end
      // axi read path
      if (s_axi_arvalid && s_axi_arready) begin
         r_d.rvalid = 1'b1;
         r_d.rresp  = RESP_OKAY;
         case (s_axi_araddr)
            CFG_OFS:    r_d.rdata = r_q.cfg;
            LIMIT_OFS:  r_d.rdata = r_q.limit;
            CTRL_OFS:   r_d.rdata = 32'h0;
            STATUS_OFS: r_d.rdata = {8'h0, r_q.valid_cnt, r_q.fail_cnt,
                                     2'h0, r_q.woken, r_q.asleep, r_q.st};
            default: begin
               r_d.rdata = 32'h0;
               r_d.rresp = RESP_SLVERR;
            end
         endcase
      end else if (r_q.rvalid && s_axi_rready) begin
         r_d.rvalid = 1'b0;
      end

      // wake observation, set wins over clear
      r_d.woken = r_q.woken | wake_seen;

      case (r_q.st)
         ST_DEFCFG: begin
            if (c_lslp) begin
               r_d.asleep = 1'b1;
               r_d.lwake  = 1'b0;
               r_d.woken  = wake_seen;
            end
            if (c_rwake && r_q.asleep) begin
               r_d.rwake_pend = 1'b1;
            end
            if (trig) begin
               r_d.st = ST_CONFIG;
            end
         end
         ST_CONFIG: begin
            if (startup_ok && !startup_fail) begin
               r_d.st = ST_READY;
            end
         end
         ST_READY: begin
            r_d.fail_cnt  = '0;
            r_d.valid_cnt = '0;
            if ((c_rwake || r_q.rwake_pend) && !all_awake) begin
               r_d.st         = ST_WAKEUP;
               r_d.rwake_pend = 1'b0;
               r_d.wpat       = 1'b1;
            end else begin
               // integration only once all awake
               r_d.cs_int   = all_awake && coldstart;
               r_d.join_int = all_awake && !coldstart;
               if (all_awake && integration_ok) begin
                  r_d.st       = ST_NACTIVE;
                  r_d.sf_en    = coldstart;
                  r_d.cs_int   = 1'b0;
                  r_d.join_int = 1'b0;
                  r_d.comm     = 1'b1;
                  // channels are up: node counts as awake from here on
                  r_d.asleep     = 1'b0;
                  r_d.rwake_pend = 1'b0;
               end
            end
         end
         ST_WAKEUP: begin
            // only the configured channel is woken here
            if (r_q.woken[r_q.cfg[CFG_WCH_BIT]] || wake_seen[r_q.cfg[CFG_WCH_BIT]]) begin
               r_d.st   = ST_READY;
               r_d.wpat = 1'b0;
            end
         end
         ST_NACTIVE, ST_NPASSIVE: begin
            r_d.fail_cnt = cc_failed ? fail_nx : r_q.fail_cnt;
            if (r_q.st == ST_NACTIVE && fail_nx >= lim_pas) begin
               r_d.st        = ST_NPASSIVE;
               r_d.valid_cnt = '0;
            end
            if (r_q.st == ST_NPASSIVE && cc_valid) begin
               r_d.valid_cnt = r_q.valid_cnt + 1'b1;
               if (r_q.valid_cnt + 1'b1 >= lim_act) begin
                  r_d.st       = ST_NACTIVE;
                  r_d.fail_cnt = '0;
               end
            end
            if (fail_nx >= lim_fat || c_stop) begin
               r_d.st = ST_HALT;
            end
         end
         ST_HALT: begin
            if (c_stop) begin
               r_d.st = ST_DEFCFG;
            end
         end
         default: r_d.st = ST_DEFCFG;
      endcase

      // stop from Config, Ready or Wakeup also ends in Halt
      if (c_stop && (r_q.st == ST_CONFIG || r_q.st == ST_READY || r_q.st == ST_WAKEUP)) begin
         r_d.st = ST_HALT;
      end
      if (r_d.st == ST_HALT) begin
         r_d.sf_en    = 1'b0;
         r_d.cs_int   = 1'b0;
         r_d.join_int = 1'b0;
         r_d.wpat     = 1'b0;
         r_d.comm     = 1'b0;
         // no stale wake request carried into the next start
         r_d.rwake_pend = 1'b0;
      end
      if (r_q.st == ST_HALT && c_stop && auto_sleep) begin
         r_d.asleep = 1'b1;
         r_d.woken  = wake_seen;
      end
      if (wr_fire && r_q.aw_addr == CFG_OFS && r_d.cfg[CFG_ASLP_BIT]
          && !r_q.cfg[CFG_ASLP_BIT]) begin
         r_d.asleep = 1'b1;
         r_d.woken  = wake_seen;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_q       <= '0;
         r_q.cfg   <= CFG_RST;
         r_q.limit <= LIMIT_RST;
         r_q.st    <= ST_DEFCFG;
         r_q.asleep <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   assign s_axi_awready        = !r_q.aw_got && !r_q.bvalid;
   assign s_axi_wready         = !r_q.w_got && !r_q.bvalid;
   assign s_axi_bvalid         = r_q.bvalid;
   assign s_axi_bresp          = r_q.bresp;
   assign s_axi_arready        = !r_q.rvalid;
   assign s_axi_rvalid         = r_q.rvalid;
   assign s_axi_rdata          = r_q.rdata;
   assign s_axi_rresp          = r_q.rresp;
   assign startup_frame_en     = r_q.sf_en;
   assign startup_slot         = r_q.cfg[CFG_KEY_LSB +: CFG_KEY_W];
   assign startup_null_payload = r_q.sf_en && (key_slot != '0);
   assign coldstart_integrate  = r_q.cs_int;
   assign join_integrate       = r_q.join_int;
   assign wake_pattern_en      = r_q.wpat;
   assign wake_channel         = r_q.cfg[CFG_WCH_BIT];
   assign comm_active          = r_q.comm;
   assign poc_state            = r_q.st;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_stop_in_halt;
      r_q.st == ST_HALT && c_stop;
   endsequence

   a_trig_to_config: assert property (@(posedge aclk) disable iff (!aresetn)
      r_q.st == ST_DEFCFG && trig |=> r_q.st == ST_CONFIG) else $error("no config");
   a_cfg_to_ready: assert property (@(posedge aclk) disable iff (!aresetn)
      r_q.st == ST_CONFIG && startup_ok && !startup_fail && !c_stop |=> r_q.st == ST_READY)
      else $error("no ready");
   a_ready_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      r_q.st == ST_READY && $past(r_q.st) == ST_READY && !$past(all_awake)
      |-> !r_q.cs_int && !r_q.join_int) else $error("early integrate");
   a_active_needs: assert property (@(posedge aclk) disable iff (!aresetn)
      r_q.st == ST_NACTIVE && $past(r_q.st) == ST_READY |-> $past(all_awake && integration_ok))
      else $error("bad active");
   a_key_zero_none: assert property (@(posedge aclk) disable iff (!aresetn)
      key_slot == '0 && !osf_flag && $stable(r_q.cfg) && r_q.st == ST_NACTIVE
      && $past(r_q.st) == ST_READY |-> !r_q.sf_en) else $error("frame on zero");
   a_wake_pattern: assert property (@(posedge aclk) disable iff (!aresetn)
      r_q.st == ST_WAKEUP |-> r_q.wpat) else $error("no pattern");
   a_passive_drop: assert property (@(posedge aclk) disable iff (!aresetn)
      r_q.st == ST_NACTIVE && fail_nx >= lim_pas && fail_nx < lim_fat && !c_stop
      |=> r_q.st == ST_NPASSIVE) else $error("no passive");
   a_fatal_halt: assert property (@(posedge aclk) disable iff (!aresetn)
      (r_q.st == ST_NACTIVE || r_q.st == ST_NPASSIVE) && fail_nx >= lim_fat
      |=> r_q.st == ST_HALT && !r_q.comm) else $error("no halt");
   a_halt_exit: assert property (@(posedge aclk) disable iff (!aresetn)
      s_stop_in_halt |=> r_q.st == ST_DEFCFG) else $error("no default");
endmodule : frsw_top

// *** verification/frsw_node_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------
// peer nodes on the cluster
// ----------------------------------------------------------------
module frsw_node_model
   import frsw_pkg::*;
#(
   parameter int INTEG_DLY = 3
)
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [2:0] poc_state,
   input  wire logic       coldstart_integrate,
   input  wire logic       join_integrate,
   input  wire logic       wake_pattern_en,
   input  wire logic       wake_channel,
   input  wire logic       hold_cfg,
   input  wire logic       peer_wake,
   output logic            startup_ok,
   output logic            startup_fail,
   output logic            integration_ok,
   output logic [1:0]      wake_seen
);
   import frsw_pkg::*;
   logic [3:0] integ_cnt_q;
   logic       wake_busy_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         integ_cnt_q <= 4'h0;
         wake_busy_q <= 1'b0;
         wake_seen   <= 2'h0;
      end else begin
         wake_seen <= 2'h0;
         // second coldstart clock joins once this node integrates
         if (coldstart_integrate || join_integrate) begin
            if (integ_cnt_q != 4'(INTEG_DLY)) integ_cnt_q <= integ_cnt_q + 4'h1;
         end else begin
            integ_cnt_q <= 4'h0;
         end
         if (wake_pattern_en && !wake_busy_q) begin
            wake_seen[wake_channel] <= 1'b1;
            wake_busy_q             <= 1'b1;
         end else if (!wake_pattern_en) begin
            wake_busy_q <= 1'b0;
         end
         // another node wakes the channel this node leaves alone
         if (peer_wake) wake_seen[!wake_channel] <= 1'b1;
      end
   end

   assign integration_ok = (integ_cnt_q == 4'(INTEG_DLY));
   assign startup_ok     = (poc_state == ST_CONFIG) && !hold_cfg;
   assign startup_fail   = hold_cfg;
endmodule : frsw_node_model

// *** verification/frsw_top_tb.sv ***
`timescale 1ns/100ps
module frsw_top_tb;
   import frsw_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, ext_start_trigger, startup_ok, startup_fail, integration_ok;
   logic cc_failed, cc_valid, startup_frame_en, startup_null_payload, coldstart_integrate;
   logic join_integrate, wake_pattern_en, wake_channel, comm_active, hold_cfg, peer_wake;
   logic [7:0]           s_axi_awaddr, s_axi_araddr;
   logic [31:0]          s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]           s_axi_wstrb;
   logic [1:0]           s_axi_bresp, s_axi_rresp, wake_seen, rr, br;
   logic [CFG_KEY_W-1:0] startup_slot;
   logic [2:0]           poc_state;
   logic                 seen_join, seen_cold, seen_wake, seen_pat;
   int                   err_total, checks_done, cycles;

   frsw_top i_frsw_top (.*);
   frsw_node_model i_frsw_node_model (.*);

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (join_integrate === 1'b1) seen_join <= 1'b1;
      if (coldstart_integrate === 1'b1) seen_cold <= 1'b1;
      if (poc_state === ST_WAKEUP) seen_wake <= 1'b1;
      if (wake_pattern_en === 1'b1) seen_pat <= 1'b1;
      if (cycles == 20000) begin
         err_total++;
         finish_test();
      end
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok  = 1'b0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      br = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      @(posedge aclk);
      while (s_axi_arready !== 1'b1) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_read

   task automatic ctrl(input int b);
      axi_write(CTRL_OFS, 32'h1 << b);
   endtask : ctrl

   task automatic chk_state(input frsw_state_t s, input int wt);
      int n;
      n = 0;
      while (poc_state !== s && n < wt) begin
         @(posedge aclk);
         n++;
      end
      check(32'(poc_state), 32'(s));
   endtask : chk_state

   task automatic chk_sleep(input logic exp);
      axi_read(STATUS_OFS);
      check(32'(rd[3]), 32'(exp));
   endtask : chk_sleep

   task automatic pulse_cc(input logic fail, input int n);
      repeat (n) begin
         @(posedge aclk);
         cc_failed <= fail;
         cc_valid  <= !fail;
         @(posedge aclk);
         cc_failed <= 1'b0;
         cc_valid  <= 1'b0;
         repeat (2) @(posedge aclk);
      end
   endtask : pulse_cc

   task automatic halt_reset;
      ctrl(CTRL_STOP_BIT);
      chk_state(ST_HALT, 50);
      ctrl(CTRL_STOP_BIT);
      chk_state(ST_DEFCFG, 50);
      seen_join = 1'b0;
      seen_cold = 1'b0;
      seen_wake = 1'b0;
      seen_pat  = 1'b0;
   endtask : halt_reset

   task automatic end_test(input string name);
      $display("test %s finished, errors so far %0d", name, err_total);
   endtask : end_test

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, ext_start_trigger, cc_failed, cc_valid, hold_cfg, peer_wake} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      {seen_join, seen_cold, seen_wake, seen_pat} = '0;
      {err_total, checks_done, cycles} = '0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk_state(ST_DEFCFG, 0);
      check(32'(comm_active), 32'h0);
      chk_sleep(1'b0);
      axi_read(CFG_OFS);
      check(rd, CFG_RST);
      axi_read(LIMIT_OFS);
      check(rd, LIMIT_RST);
      axi_read(8'h10);
      check(32'(rr), 32'(RESP_SLVERR));
      axi_write(8'h10, 32'h0);
      check(32'(br), 32'(RESP_SLVERR));
      end_test("reset");
      ctrl(CTRL_START_BIT);
      chk_state(ST_NACTIVE, 200);
      check(32'(seen_join), 32'h1);
      check(32'(seen_cold), 32'h0);
      check(32'(startup_frame_en), 32'h0);
      check(32'(comm_active), 32'h1);
      halt_reset();
      end_test("join");
      // key slot 5 chosen apart from the peers' frames
      axi_write(CFG_OFS, CFG_RST | 32'h5);
      check(32'(br), 32'(RESP_OKAY));
      ctrl(CTRL_START_BIT);
      chk_state(ST_NACTIVE, 200);
      check(32'({startup_frame_en, startup_null_payload}), 32'h3);
      check(32'(startup_slot), 32'h5);
      check(32'(seen_cold), 32'h1);
      pulse_cc(1'b1, 2);
      chk_state(ST_NPASSIVE, 20);
      pulse_cc(1'b0, 2);
      chk_state(ST_NACTIVE, 20);
      halt_reset();
      end_test("key slot");
      axi_write(CFG_OFS, CFG_RST | (32'h1 << CFG_OSF_BIT));
      ctrl(CTRL_START_BIT);
      chk_state(ST_NACTIVE, 200);
      check(32'({startup_frame_en, startup_null_payload}), 32'h2);
      pulse_cc(1'b1, 4);
      chk_state(ST_HALT, 20);
      ctrl(CTRL_STOP_BIT);
      chk_state(ST_DEFCFG, 50);
      end_test("fatal");
      axi_write(CFG_OFS, CFG_RST | (32'h1 << CFG_EXTSYN_BIT));
      hold_cfg <= 1'b1;
      ctrl(CTRL_START_BIT);
      repeat (10) @(posedge aclk);
      chk_state(ST_DEFCFG, 0);
      ext_start_trigger <= 1'b1;
      @(posedge aclk);
      ext_start_trigger <= 1'b0;
      repeat (10) @(posedge aclk);
      chk_state(ST_CONFIG, 0);
      hold_cfg <= 1'b0;
      chk_state(ST_NACTIVE, 200);
      halt_reset();
      // soft trigger bit stands in for the external trigger
      hold_cfg <= 1'b1;
      ctrl(CTRL_TRIG_BIT);
      chk_state(ST_CONFIG, 20);
      halt_reset();
      hold_cfg <= 1'b0;
      end_test("ext sync");
      axi_write(CFG_OFS, CFG_RST);
      ctrl(CTRL_LSLP_BIT);
      chk_sleep(1'b1);
      ctrl(CTRL_START_BIT);
      chk_state(ST_READY, 200);
      repeat (20) @(posedge aclk);
      chk_state(ST_READY, 0);
      check(32'({seen_join, seen_cold}), 32'h0);
      ctrl(CTRL_RWAKE_BIT);
      chk_state(ST_READY, 50);
      check(32'({seen_wake, seen_pat, wake_channel}), 32'h6);
      repeat (10) @(posedge aclk);
      chk_state(ST_READY, 0);
      @(posedge aclk);
      peer_wake <= 1'b1;
      @(posedge aclk);
      peer_wake <= 1'b0;
      chk_state(ST_NACTIVE, 200);
      halt_reset();
      end_test("local sleep");
      axi_write(CFG_OFS, CFG_RST | (32'h1 << CFG_ASLP_BIT) | (32'h1 << CFG_WCH_BIT));
      chk_sleep(1'b1);
      ctrl(CTRL_RWAKE_BIT);
      ctrl(CTRL_START_BIT);
      chk_state(ST_READY, 200);
      repeat (5) @(posedge aclk);
      check(32'({seen_wake, seen_pat, wake_channel}), 32'h7);
      peer_wake <= 1'b1;
      @(posedge aclk);
      peer_wake <= 1'b0;
      chk_state(ST_NACTIVE, 200);
      chk_sleep(1'b0);
      halt_reset();
      chk_sleep(1'b1);
      end_test("auto sleep");
      finish_test();
   end
endmodule : frsw_top_tb
